// ===== hw/fe_pcs_pkg.sv
// Package of constants and types for the 100 Mbit/s coding and attachment block.
package fe_pcs_pkg;

  // ----------------------------------------------------------------------
  // Code groups
  // ----------------------------------------------------------------------
  localparam logic [4:0] CG_IDLE = 5'h1f;
  localparam logic [4:0] CG_J = 5'h18;
  localparam logic [4:0] CG_K = 5'h11;
  localparam logic [4:0] CG_T = 5'h0d;
  localparam logic [4:0] CG_R = 5'h07;
  localparam logic [4:0] CG_H = 5'h04;
  localparam logic [3:0] NIB_PREAMBLE = 4'h5;
  localparam logic [3:0] NIB_INVALID = 4'h5;

  // ----------------------------------------------------------------------
  // Scrambler
  // ----------------------------------------------------------------------
  localparam int SCR_LEN = 11;
  localparam logic [5:0] SEED_FIXED = 6'h2d;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_KHZ = 25000;
  localparam int LINK_UP_TIME_MS = 50;
  localparam int LINK_UP_CYCLES = LINK_UP_TIME_MS * CLK_KHZ;
  localparam int WINDOW_TIME_MS = 2;
  localparam int WINDOW_CYCLES = WINDOW_TIME_MS * CLK_KHZ;
  localparam int TIMER_W = 22;
  localparam logic [4:0] IDLE_RUN_MIN = 5'h10;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_CFG = 8'h10;
  localparam int CTRL_AN_EN_BIT = 12;
  localparam int STAT_LINK_BIT = 2;
  localparam int STAT_POL_BIT = 5;
  localparam int STAT_LINK2_BIT = 10;
  localparam int STAT_LOCK_BIT = 0;
  localparam int STAT_CRS_BIT = 1;
  localparam int CFG_OVERRIDE_BIT = 14;
  localparam int CFG_BYPASS_BIT = 12;
  localparam logic [15:0] CTRL_RESET = 16'h1000;
  localparam logic [15:0] CFG_RESET = 16'h0000;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic en;
    logic [3:0] data;
  } mii_tx_t;

  typedef struct packed {
    logic dv;
    logic er;
    logic crs;
    logic [3:0] data;
  } mii_rx_t;

endpackage

// ===== hw/fast_ethernet_pcs_pma.sv
// Coding, scrambling, delimiting and link logic of a 100 Mbit/s transceiver.
//
// Functional notes
// - With transmit enable low, idle code group 11111 is sent continuously.
// - First two nibbles of a frame are replaced by J then K.
// - Later nibbles are encoded until transmit enable falls, then T, R and idle.
// - Data nibbles use the fixed sixteen-entry five-bit mapping both ways.
// - End delimiter is T immediately followed by R.
// - Each transmitted frame ends with T and R, then idle resumes.
// - 00100 is transmit error; listed groups are invalid. The transmit side has no error input and never sends 00100.
// - Invalid received symbol raises receive error and drives nibble 0101.
// - Received J and K become two preamble nibbles passed to the MAC.
// - Receive valid rises with first preamble nibble, only for valid symbols.
// - Link comes up after descrambler lock holds for about 50 ms.
// - Link drops when a 2 ms window lacks 16 consecutive idles.
// - No permanent 10 Mbit/s link is ever settled on.
// - Link loss shows in status bits; negotiation restarts when enabled.
// - Frames go out only with link up unless override is set.
// - Negotiation enabled and link down sends pulse bursts instead.
// - Carrier sense rises on J, drops again if K does not follow, and falls on T R.
// - Idle without T R drops carrier and pulses receive error once.
// - Scrambler seed is eleven bits, five from the low bits written to the configuration register.
// - Descrambler locks on received idles with no software help.
// - Bypass bit passes code groups without scrambling or descrambling.
// - Polarity status carries no meaning at 100 Mbit/s.
module fast_ethernet_pcs_pma
  import fe_pcs_pkg::*;
#(
  parameter int LINK_UP_CYCLES_P = LINK_UP_CYCLES,
  parameter int WINDOW_CYCLES_P = WINDOW_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [15:0] reg_rdata_out,
  input wire mii_tx_t mii_tx_in,
  output mii_rx_t mii_rx_out,
  output logic [4:0] line_tx_sym_out,
  output logic flp_burst_out,
  output logic an_restart_out,
  input wire logic line_rx_clk_in,
  input wire logic [4:0] line_rx_sym_in
);

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  function automatic logic [4:0] encode(input logic [3:0] n);
    logic [4:0] c;
    c = CG_IDLE;
    case (n)
      4'h0: c = 5'h1e;
      4'h1: c = 5'h09;
      4'h2: c = 5'h14;
      4'h3: c = 5'h15;
      4'h4: c = 5'h0a;
      4'h5: c = 5'h0b;
      4'h6: c = 5'h0e;
      4'h7: c = 5'h0f;
      4'h8: c = 5'h12;
      4'h9: c = 5'h13;
      4'ha: c = 5'h16;
      4'hb: c = 5'h17;
      4'hc: c = 5'h1a;
      4'hd: c = 5'h1b;
      4'he: c = 5'h1c;
      default: c = 5'h1d;
    endcase
    return c;
  endfunction

  // Returns a valid flag and the nibble; control and invalid groups give flag 0 and nibble 0101.
  function automatic logic [4:0] decode(input logic [4:0] c);
    logic [3:0] n;
    logic ok;
    n = NIB_INVALID;
    ok = 1'b0;
    for (int i = 0; i < 16; i++) begin
      if (encode(4'(i)) == c) begin
        n = 4'(i);
        ok = 1'b1;
      end
    end
    return {ok, n};
  endfunction

  // Scrambles (dir 0) or descrambles (dir 1) one group, bit 0 first.
  function automatic logic [15:0] scr(input logic [10:0] sr_in,
                                      input logic [4:0] c, input logic dir);
    logic [10:0] sr;
    logic [4:0] o;
    sr = sr_in;
    o = 5'h00;
    for (int b = 0; b < 5; b++) begin
      o[b] = c[b] ^ sr[10] ^ sr[8];
      sr = {sr[9:0], dir ? c[b] : o[b]};
    end
    return {sr, o};
  endfunction

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  logic [15:0] ctrl;
  logic [15:0] cfg;
  logic link_up;
  logic locked;
  logic an_en;
  logic override;
  logic bypass;

  assign an_en = ctrl[CTRL_AN_EN_BIT];
  assign override = cfg[CFG_OVERRIDE_BIT];
  assign bypass = cfg[CFG_BYPASS_BIT];

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      ctrl <= CTRL_RESET;
      cfg <= CFG_RESET;
    end else if (reg_write_in) begin
      if (reg_addr_in == OFS_CTRL) begin
        ctrl <= reg_wdata_in;
      end
      if (reg_addr_in == OFS_CFG) begin
        cfg <= reg_wdata_in;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_read_in) begin
      case (reg_addr_in)
        OFS_CTRL: reg_rdata_out <= ctrl;
        OFS_CFG: reg_rdata_out <= cfg;
        OFS_STAT: begin
          reg_rdata_out <= 16'h0000;
          reg_rdata_out[STAT_LINK_BIT] <= link_up;
          reg_rdata_out[STAT_LINK2_BIT] <= link_up;
          reg_rdata_out[STAT_POL_BIT] <= 1'b0;
          reg_rdata_out[STAT_LOCK_BIT] <= locked;
          reg_rdata_out[STAT_CRS_BIT] <= mii_rx_out.crs;
        end
        default: reg_rdata_out <= 16'h0000;
      endcase
    end else begin
      reg_rdata_out <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------------
  // Transmit path
  // ----------------------------------------------------------------------
  typedef enum logic [5:0] {
    TX_IDLE = 6'h01,
    TX_K = 6'h02,
    TX_DATA = 6'h04,
    TX_R = 6'h08,
    TX_BLOCK = 6'h10
  } tx_state_t;

  tx_state_t tx_state;
  tx_state_t next_tx_state;
  logic [4:0] tx_code;
  logic [10:0] tx_sr;
  logic [15:0] tx_scr;
  logic tx_allowed;

  assign tx_allowed = (link_up || override) && !flp_burst_out;

  always_comb begin
    tx_code = CG_IDLE;
    next_tx_state = tx_state;
    case (tx_state)
      TX_IDLE: begin
        if (mii_tx_in.en && tx_allowed) begin
          tx_code = CG_J;
          next_tx_state = TX_K;
        end else if (mii_tx_in.en) begin
          next_tx_state = TX_BLOCK;
        end
      end
      TX_K: begin
        tx_code = CG_K;
        next_tx_state = TX_DATA;
      end
      TX_DATA: begin
        if (mii_tx_in.en) begin
          tx_code = encode(mii_tx_in.data);
        end else begin
          tx_code = CG_T;
          next_tx_state = TX_R;
        end
      end
      TX_R: begin
        tx_code = CG_R;
        next_tx_state = TX_IDLE;
      end
      TX_BLOCK: begin
        if (!mii_tx_in.en) begin
          next_tx_state = TX_IDLE;
        end
      end
      default: next_tx_state = TX_IDLE;
    endcase
  end

  assign tx_scr = scr(tx_sr, tx_code, 1'b0);

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      tx_state <= TX_IDLE;
    end else begin
      tx_state <= next_tx_state;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      tx_sr <= {SEED_FIXED, CFG_RESET[4:0]};
      line_tx_sym_out <= CG_IDLE;
    end else if (reg_write_in && reg_addr_in == OFS_CFG) begin
      tx_sr <= {SEED_FIXED, reg_wdata_in[4:0]};
      line_tx_sym_out <= bypass ? tx_code : tx_scr[4:0];
    end else begin
      tx_sr <= tx_scr[15:5];
      line_tx_sym_out <= bypass ? tx_code : tx_scr[4:0];
    end
  end

  // Pulse bursts replace frames while negotiating without link.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      flp_burst_out <= 1'b0;
    end else begin
      flp_burst_out <= an_en && !link_up;
    end
  end

  // ----------------------------------------------------------------------
  // Line receive sampling
  // ----------------------------------------------------------------------
  logic [2:0] rclk_sync;
  logic [4:0] rsym_sync [3];
  logic rclk_state;
  logic sym_stb;

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      rclk_sync <= 3'h0;
      rclk_state <= 1'b0;
      sym_stb <= 1'b0;
    end else begin
      rclk_sync <= {rclk_sync[1:0], line_rx_clk_in};
      sym_stb <= 1'b0;
      if (rclk_sync[1] == rclk_sync[2] && rclk_sync[2] != rclk_state) begin
        rclk_state <= rclk_sync[2];
        sym_stb <= rclk_sync[2];
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    rsym_sync[0] <= line_rx_sym_in;
    rsym_sync[1] <= rsym_sync[0];
    rsym_sync[2] <= rsym_sync[1];
  end

  // ----------------------------------------------------------------------
  // Descrambler and lock
  // ----------------------------------------------------------------------
  logic [10:0] rx_sr;
  logic [15:0] rx_dscr;
  logic [4:0] rx_code;
  logic [4:0] idle_run;
  logic win_ok;
  logic [TIMER_W-1:0] lock_timer;
  logic [TIMER_W-1:0] win_timer;
  logic win_end;

  assign rx_dscr = scr(rx_sr, rsym_sync[2], 1'b1);
  assign rx_code = bypass ? rsym_sync[2] : rx_dscr[4:0];
  assign win_end = win_timer == TIMER_W'(WINDOW_CYCLES_P - 1);

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      rx_sr <= 11'h000;
      idle_run <= 5'h00;
    end else if (sym_stb) begin
      rx_sr <= rx_dscr[15:5];
      if (rx_code != CG_IDLE) begin
        idle_run <= 5'h00;
      end else if (idle_run != IDLE_RUN_MIN) begin
        idle_run <= idle_run + 5'h01;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      locked <= 1'b0;
    end else if (sym_stb && idle_run == IDLE_RUN_MIN - 5'h01 &&
                 rx_code == CG_IDLE) begin
      locked <= 1'b1;
    end else if (win_end && !win_ok) begin
      locked <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      win_timer <= '0;
      win_ok <= 1'b0;
    end else begin
      win_timer <= win_end ? '0 : win_timer + 1'b1;
      if (win_end) begin
        win_ok <= idle_run == IDLE_RUN_MIN;
      end else if (idle_run == IDLE_RUN_MIN) begin
        win_ok <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Link state
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      lock_timer <= '0;
      link_up <= 1'b0;
      an_restart_out <= 1'b0;
    end else begin
      an_restart_out <= 1'b0;
      if (!locked) begin
        lock_timer <= '0;
      end else if (lock_timer != TIMER_W'(LINK_UP_CYCLES_P)) begin
        lock_timer <= lock_timer + 1'b1;
      end
      if (link_up && win_end && !win_ok) begin
        link_up <= 1'b0;
        an_restart_out <= an_en;
      end else if (!link_up && locked &&
                   lock_timer == TIMER_W'(LINK_UP_CYCLES_P - 1)) begin
        link_up <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Receive framing
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    RX_IDLE = 4'h1,
    RX_GOT_J = 4'h2,
    RX_DATA = 4'h4,
    RX_GOT_T = 4'h8
  } rx_state_t;

  rx_state_t rx_state;
  logic [4:0] rx_dec;
  logic er_pulse;

  assign rx_dec = decode(rx_code);

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      rx_state <= RX_IDLE;
      mii_rx_out <= '0;
      er_pulse <= 1'b0;
    end else if (sym_stb) begin
      er_pulse <= 1'b0;
      mii_rx_out.er <= 1'b0;
      case (rx_state)
        RX_IDLE: begin
          if (rx_code == CG_J) begin
            rx_state <= RX_GOT_J;
            mii_rx_out.crs <= 1'b1;
            mii_rx_out.dv <= 1'b1;
            mii_rx_out.data <= NIB_PREAMBLE;
          end
        end
        RX_GOT_J: begin
          if (rx_code == CG_K) begin
            rx_state <= RX_DATA;
            mii_rx_out.data <= NIB_PREAMBLE;
          end else begin
            rx_state <= RX_IDLE;
            mii_rx_out <= '0;
          end
        end
        RX_DATA: begin
          if (rx_code == CG_T) begin
            rx_state <= RX_GOT_T;
            mii_rx_out.dv <= 1'b0;
          end else if (rx_code == CG_IDLE) begin
            rx_state <= RX_IDLE;
            mii_rx_out <= '0;
            mii_rx_out.er <= 1'b1;
            er_pulse <= 1'b1;
          end else if (rx_dec[4]) begin
            mii_rx_out.dv <= 1'b1;
            mii_rx_out.data <= rx_dec[3:0];
          end else begin
            mii_rx_out.dv <= 1'b0;
            mii_rx_out.er <= 1'b1;
            mii_rx_out.data <= NIB_INVALID;
          end
        end
        RX_GOT_T: begin
          rx_state <= RX_IDLE;
          mii_rx_out <= '0;
          if (rx_code != CG_R) begin
            mii_rx_out.er <= 1'b1;
            mii_rx_out.data <= NIB_INVALID;
          end
        end
        default: begin
          rx_state <= RX_IDLE;
          mii_rx_out <= '0;
        end
      endcase
    end else if (er_pulse) begin
      er_pulse <= 1'b0;
      mii_rx_out.er <= 1'b0;
    end
  end

endmodule

// ===== testbench/fe_pcs_properties.sv
// Checker of the coding block's port behaviour.
module fe_pcs_checker
  import fe_pcs_pkg::*;
#(
  parameter int LINK_UP_CYCLES_P = 200,
  parameter int WINDOW_CYCLES_P = 400
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire mii_tx_t mii_tx_in,
  input wire mii_rx_t mii_rx_out,
  input wire logic [4:0] line_tx_sym_out,
  input wire logic flp_burst_out,
  input wire logic an_restart_out
);
  logic byp;
  logic byp_d;
  logic on;
  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  // --------
  // Bypass tracking, so raw code groups can be judged.
  // --------
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      byp <= 1'b0;
      byp_d <= 1'b0;
    end else begin
      byp_d <= byp;
      if (reg_write_in && reg_addr_in == OFS_CFG) begin
        byp <= reg_wdata_in[CFG_BYPASS_BIT];
      end
    end
  end
  assign on = byp && byp_d;
  sequence s_start_pair;
    line_tx_sym_out == CG_J ##1 line_tx_sym_out == CG_K;
  endsequence
  sequence s_end_pair;
    line_tx_sym_out == CG_T ##1 line_tx_sym_out == CG_R;
  endsequence
  a_start_pair: assert property (
    on && line_tx_sym_out == CG_J |-> s_start_pair)
    else $error("start group J not followed by K");
  a_end_pair: assert property (
    on && line_tx_sym_out == CG_T |-> s_end_pair ##1 line_tx_sym_out == CG_IDLE)
    else $error("end pair or idle after it missing");
  a_idle_fill: assert property (
    (!mii_tx_in.en) [*4] ##1 on |-> line_tx_sym_out == CG_IDLE)
    else $error("no idle while transmit enable low");
  a_flp_idle: assert property (
    (flp_burst_out && on) [*4] |-> line_tx_sym_out == CG_IDLE)
    else $error("frame data sent while bursts forced");
  a_dv_carrier: assert property (
    mii_rx_out.dv |-> mii_rx_out.crs)
    else $error("receive valid without carrier");
  a_crs_preamble: assert property (
    $rose(mii_rx_out.crs) |-> mii_rx_out.dv && mii_rx_out.data == NIB_PREAMBLE)
    else $error("carrier start without preamble nibble");
  a_bad_nibble: assert property (
    mii_rx_out.er && mii_rx_out.crs
      |-> mii_rx_out.data == NIB_INVALID && !mii_rx_out.dv)
    else $error("bad group not shown as error nibble");
  a_false_carrier: assert property (
    $fell(mii_rx_out.crs) && mii_rx_out.er |=> !mii_rx_out.er)
    else $error("false carrier error longer than one clock");
  a_restart_pulse: assert property (
    an_restart_out |=> !an_restart_out)
    else $error("restart longer than one clock");
endmodule

bind fast_ethernet_pcs_pma fe_pcs_checker #(
  .LINK_UP_CYCLES_P(LINK_UP_CYCLES_P),
  .WINDOW_CYCLES_P(WINDOW_CYCLES_P)
) u_fe_pcs_checker (.core_clk_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in,
  .reg_write_in, .mii_tx_in, .mii_rx_out, .line_tx_sym_out, .flp_burst_out,
  .an_restart_out);

// ===== testbench/line_peer.sv
// Line-side peer that sends code groups on its own free-running clock.
module line_peer
  import fe_pcs_pkg::*;
(
  output logic line_clk_out,
  output logic [4:0] line_sym_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] tx_q[$];
  initial begin
    line_clk_out = 1'b0;
    line_sym_out = CG_IDLE;
    #13;
    forever begin
      #160 line_clk_out = 1'b1;
      #160 line_clk_out = 1'b0;
      // Groups change on the falling edge, idle fill when nothing queued.
      line_sym_out = (tx_q.size() > 0) ? tx_q.pop_front() : CG_IDLE;
    end
  end
endmodule

// ===== testbench/fast_ethernet_pcs_pma_bench.sv
// Self-checking bench of the coding and attachment block.
module fast_ethernet_pcs_pma_bench import fe_pcs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] ENC [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a,
    5'h0b, 5'h0e, 5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c,
    5'h1d};
  localparam logic [4:0] BAD [11] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h05,
    5'h06, 5'h08, 5'h0c, 5'h10, 5'h19, 5'h04};
  logic clk, rst, wr, rd, flp, restart, lclk;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, d;
  logic [4:0] sym, lsym;
  mii_tx_t tx;
  mii_rx_t rx;
  int error_cnt = 0;
  int num_checks = 0;
  fast_ethernet_pcs_pma #(.LINK_UP_CYCLES_P(200), .WINDOW_CYCLES_P(400))
  u_fast_ethernet_pcs_pma (.core_clk_in(clk), .sys_rst_in(rst),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr),
    .reg_read_in(rd), .reg_rdata_out(rdata), .mii_tx_in(tx),
    .mii_rx_out(rx), .line_tx_sym_out(sym), .flp_burst_out(flp),
    .an_restart_out(restart), .line_rx_clk_in(lclk), .line_rx_sym_in(lsym));
  line_peer u_line_peer (.line_clk_out(lclk), .line_sym_out(lsym));
  // --------
  // Shared tasks
  // --------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic tx_frame(input logic ok);
    logic [4:0] exp[$];
    int n;
    exp = {CG_J, CG_K};
    for (int i = 0; i < 16; i++) exp.push_back(ENC[i]);
    exp.push_back(CG_T);
    exp.push_back(CG_R);
    exp.push_back(CG_IDLE);
    fork
      begin
        for (int i = 0; i < 18; i++) begin
          @(posedge clk);
          tx <= '{1'b1, (i < 2) ? 4'h5 : 4'(i - 2)};
        end
        @(posedge clk);
        tx.en <= 1'b0;
      end
      begin
        n = 0;
        while (ok && sym !== CG_J && n < 6) begin
          step();
          n++;
        end
        foreach (exp[i]) begin
          check(16'(sym), ok ? 16'(exp[i]) : 16'(CG_IDLE));
          step();
        end
      end
    join
  endtask
  task automatic rx_check(input logic [4:0] s[$], input logic [6:0] w[$],
    input logic fc);
    int n;
    foreach (s[i]) u_line_peer.tx_q.push_back(s[i]);
    n = 0;
    while (rx.crs !== 1'b1 && n < 80) begin
      step();
      n++;
    end
    repeat (4) @(posedge clk);
    foreach (w[i]) begin
      #1;
      check(16'(rx), 16'(w[i]));
      if (i + 1 < w.size()) begin
        repeat (8) @(posedge clk);
      end
    end
    n = 0;
    while (rx.crs === 1'b1 && n < 40) begin
      step();
      n++;
    end
    check(16'(rx.er), 16'(fc));
    step();
    check(16'(rx), 16'h0000);
    repeat (200) @(posedge clk);
  endtask
  // --------
  // Scenarios
  // --------
  task automatic t_reset();
    reg_rd(OFS_CTRL);
    check(d, CTRL_RESET);
    reg_rd(OFS_CFG);
    check(d, CFG_RESET);
    reg_rd(8'h20);
    check(d, 16'h0000);
    check(16'(flp), 16'h0001);
  endtask
  task automatic t_link_up();
    int n;
    reg_wr(OFS_CFG, 16'h1000);
    reg_rd(OFS_STAT);
    check(d & 16'h0404, 16'h0000);
    n = 0;
    while (d[STAT_LINK_BIT] !== 1'b1 && n < 80) begin
      repeat (20) @(posedge clk);
      reg_rd(OFS_STAT);
      n++;
    end
    check(d & 16'h0425, 16'h0405);
    check(16'(flp), 16'h0000);
  endtask
  task automatic t_rx();
    logic [4:0] s[$];
    logic [6:0] w[$];
    s = {CG_J, CG_K};
    w = {7'h55, 7'h55};
    for (int i = 0; i < 16; i++) begin
      s.push_back(ENC[i]);
      w.push_back(7'h50 | 7'(i));
    end
    s.push_back(CG_T);
    s.push_back(CG_R);
    rx_check(s, w, 1'b0);
    s = {CG_J, CG_K};
    w = {7'h55, 7'h55};
    for (int i = 0; i < 11; i++) begin
      s.push_back(BAD[i]);
      w.push_back(7'h35);
    end
    s.push_back(CG_T);
    s.push_back(CG_R);
    rx_check(s, w, 1'b0);
    rx_check({CG_J, CG_K, ENC[3]}, {7'h55, 7'h55, 7'h53}, 1'b1);
    rx_check({CG_J, ENC[0]}, {7'h55}, 1'b0);
  endtask
  task automatic t_link_down();
    int n;
    repeat (150) u_line_peer.tx_q.push_back(ENC[0]);
    n = 0;
    while (restart !== 1'b1 && n < 1500) begin
      step();
      n++;
    end
    check(16'(restart), 16'h0001);
    reg_rd(OFS_STAT);
    check(d & 16'h0404, 16'h0000);
    check(16'(flp), 16'h0001);
    tx_frame(1'b0);
    reg_wr(OFS_CTRL, 16'h0000);
    reg_wr(OFS_CFG, 16'h5000);
    step();
    check(16'(flp), 16'h0000);
    tx_frame(1'b1);
  endtask
  task automatic t_scramble();
    logic [10:0] sr;
    logic [4:0] o;
    reg_wr(OFS_CFG, 16'h400b);
    sr = {SEED_FIXED, 5'h0b};
    step();
    for (int k = 0; k < 4; k++) begin
      for (int b = 0; b < 5; b++) begin
        o[b] = CG_IDLE[b] ^ sr[10] ^ sr[8];
        sr = {sr[9:0], o[b]};
      end
      check(16'(sym), 16'(o));
      step();
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #2000000;
    error_cnt++;
    give_verdict();
  end
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
    tx = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_link_up();
    tx_frame(1'b1);
    t_rx();
    t_link_down();
    t_scramble();
    give_verdict();
  end
endmodule
